// ### hw/scce_top.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "scce_cfg.svh"

module scce_top
  import scce_pkg::*;
#(
  parameter logic [11:0] REC_FAST = `SCCE_REC_FAST_CYCLES,
  parameter logic [11:0] REC_NORMAL = `SCCE_REC_NORMAL_CYCLES,
  parameter logic [3:0] STRETCH = `SCCE_STRETCH_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic int_reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire scce_cpu_req_t cpu,
  input wire logic [7:0] ad_in,
  input wire logic mode_in,
  input wire logic irq_n,
  input wire logic [7:0] kbd_in,
  input wire logic [7:0] kbd_ddr,
  input wire logic vector_fetch,
  input wire logic stop_exec,
  input wire logic wait_exec,
  input wire logic stop_exit,
  output scce_ext_bus_t ext,
  output scce_sys_out_t sys
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic stop_allow;
    logic stop_rec;
    logic wdog_en;
    logic internal_read_visibility;
    logic load_visibility;
    logic lve;
    logic [1:0] param;
    logic cfg_locked;
    logic ext_locked;
    logic k_flag;
    logic k_en;
    logic k_sens;
    logic k_latch;
    logic k_prev;
    logic i_flag;
    logic i_en;
    logic i_sens;
    logic i_latch;
    logic i_prev;
    logic mode_muxed;
    logic mode_pending;
    scce_bus_state_t st;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] last_data;
    logic is_wr;
    logic visible;
    logic [3:0] stretch_cnt;
    logic [11:0] rec_cnt;
    logic waitreq;
    logic [7:0] rdata;
    scce_ext_bus_t pins;
    scce_sys_out_t so;
  } scce_state_t;

  scce_state_t state_reg;
  scce_state_t state_next;
  scce_state_t reset_val;

  logic acc;
  logic hit_cfg;
  logic hit_eic;
  logic wr_cfg;
  logic wr_eic;
  logic [7:0] wd;
  logic [7:0] cfg_rd;
  logic [7:0] eic_rd;
  logic irq_low;
  logic set_i;
  logic kbd_low;
  logic set_k;
  logic in_page0;
  logic in_gp;
  logic in_stretch;
  logic cs1_en;
  logic cs1_page0;
  logic cs1_hit;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    reset_val = '0;
    reset_val.stop_allow = 1'(`SCCE_CFG_RESET >> `SCCE_CFG_STOP_ALLOW);
    reset_val.stop_rec = 1'(`SCCE_CFG_RESET >> `SCCE_CFG_STOP_REC);
    reset_val.wdog_en = 1'(`SCCE_CFG_RESET >> `SCCE_CFG_WDOG);
    reset_val.internal_read_visibility = 1'(`SCCE_CFG_RESET >> `SCCE_CFG_IRV);
    reset_val.load_visibility = 1'(`SCCE_CFG_RESET >> `SCCE_CFG_LOAD_VISIBILITY);
    reset_val.lve = 1'(`SCCE_CFG_RESET >> `SCCE_CFG_LVE);
    reset_val.param = 2'(`SCCE_CFG_RESET >> `SCCE_CFG_PARAM_LO);
    reset_val.k_en = 1'(`SCCE_EIC_RESET >> `SCCE_EIC_KEN);
    reset_val.k_sens = 1'(`SCCE_EIC_RESET >> `SCCE_EIC_KSENS);
    reset_val.i_en = 1'(`SCCE_EIC_RESET >> `SCCE_EIC_IEN);
    reset_val.i_sens = 1'(`SCCE_EIC_RESET >> `SCCE_EIC_ISENS);
    reset_val.i_prev = 1'b1;
    reset_val.mode_pending = 1'b1;
    reset_val.st = SCCE_IDLE;
    reset_val.waitreq = 1'b1;
    reset_val.pins.rd_n = 1'b1;
    reset_val.pins.wr_n = 1'b1;
    reset_val.pins.cs1_n = 1'b1;
    reset_val.pins.pgm_sel_n = 1'b1;
    reset_val.pins.lir_n = 1'b1;
    state_next.so.cpu_ack = 1'b0;
    state_next.so.ill_stop = 1'b0;

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    acc = avs_read | avs_write;
    hit_cfg = avs_address[1:0] == 2'h0
      && {2'h0, avs_address[7:2]} == `SCCE_CFG_INDEX;
    hit_eic = avs_address[1:0] == 2'h0
      && {2'h0, avs_address[7:2]} == `SCCE_EIC_INDEX;
    wd = avs_writedata[7:0];
    wr_cfg = avs_write & ~state_reg.waitreq & hit_cfg & avs_byteenable[0];
    wr_eic = avs_write & ~state_reg.waitreq & hit_eic & avs_byteenable[0];
    cfg_rd = {state_reg.stop_allow, state_reg.stop_rec, state_reg.wdog_en,
      state_reg.internal_read_visibility, state_reg.load_visibility, state_reg.lve, state_reg.param};
    // Acknowledge bits are strobes; they always read back as zero
    eic_rd = {state_reg.k_flag, state_reg.k_en, 1'b0, state_reg.k_sens,
      state_reg.i_flag, state_reg.i_en, 1'b0, state_reg.i_sens};
    // One wait cycle per access keeps read data a registered value
    state_next.waitreq = ~(acc & state_reg.waitreq);
    if (acc & state_reg.waitreq) begin
      if (hit_cfg & avs_read) begin
        state_next.rdata = cfg_rd;
      end else if (hit_eic & avs_read) begin
        state_next.rdata = eic_rd;
      end else begin
        state_next.rdata = 8'h00;
      end
    end

    if (wr_cfg) begin
      if (!state_reg.cfg_locked) begin
        state_next.stop_allow = wd[`SCCE_CFG_STOP_ALLOW];
        state_next.stop_rec = wd[`SCCE_CFG_STOP_REC];
        state_next.wdog_en = wd[`SCCE_CFG_WDOG];
        state_next.cfg_locked = 1'b1;
      end
      state_next.internal_read_visibility = wd[`SCCE_CFG_IRV];
      state_next.load_visibility = wd[`SCCE_CFG_LOAD_VISIBILITY];
      state_next.lve = wd[`SCCE_CFG_LVE];
      state_next.param = wd[`SCCE_CFG_PARAM_HI:`SCCE_CFG_PARAM_LO];
    end
    if (wr_eic) begin
      state_next.k_en = wd[`SCCE_EIC_KEN];
      state_next.i_en = wd[`SCCE_EIC_IEN];
      if (!state_reg.ext_locked) begin
        state_next.k_sens = wd[`SCCE_EIC_KSENS];
        state_next.i_sens = wd[`SCCE_EIC_ISENS];
        state_next.ext_locked = 1'b1;
      end
    end

    // ------------------------------------------------------------
    // External interrupt; a set in the same cycle beats an acknowledge or vector fetch clear
    // ------------------------------------------------------------
    irq_low = ~irq_n;
    state_next.i_prev = irq_n;
    set_i = (state_reg.i_prev & irq_low) | (state_reg.i_sens & irq_low);
    if (wr_eic & wd[`SCCE_EIC_IACK]) begin
      state_next.i_latch = 1'b0;
      if (!state_reg.i_sens) begin
        state_next.i_flag = 1'b0;
      end
    end
    if (vector_fetch) begin
      state_next.i_flag = 1'b0;
      state_next.i_latch = 1'b0;
    end
    if (set_i) begin
      state_next.i_latch = 1'b1;
      state_next.i_flag = 1'b1;
    end
    if (stop_exec | wait_exec) begin
      state_next.i_en = 1'b1;
    end
    state_next.so.irq_req = state_next.i_flag & state_next.i_en;

    // ------------------------------------------------------------
    // Keyboard interrupt on input-configured port lines
    // ------------------------------------------------------------
    kbd_low = |(~kbd_in & ~kbd_ddr);
    state_next.k_prev = kbd_low;
    set_k = state_reg.k_en
      & ((~state_reg.k_prev & kbd_low) | (state_reg.k_sens & kbd_low));
    if (wr_eic & wd[`SCCE_EIC_KACK]) begin
      state_next.k_latch = 1'b0;
      if (!state_reg.k_sens) begin
        state_next.k_flag = 1'b0;
      end
    end
    if (set_k) begin
      state_next.k_latch = 1'b1;
      state_next.k_flag = 1'b1;
    end
    // Wake-up from stop or wait uses this same request
    state_next.so.kbd_req = state_next.k_flag & state_next.k_en;

    // ------------------------------------------------------------
    // Stop handling and recovery count
    // ------------------------------------------------------------
    if (stop_exec & ~state_reg.stop_allow) begin
      state_next.so.ill_stop = 1'b1;
    end
    if (stop_exit) begin
      state_next.so.rec_busy = 1'b1;
      state_next.rec_cnt = (state_reg.stop_rec ? REC_NORMAL : REC_FAST)
        - 12'h001;
    end else if (state_reg.so.rec_busy) begin
      if (state_reg.rec_cnt == 12'h000) begin
        state_next.so.rec_busy = 1'b0;
      end else begin
        state_next.rec_cnt = state_reg.rec_cnt - 12'h001;
      end
    end
    state_next.so.wdog_en = state_next.wdog_en;
    state_next.so.lve_en = state_next.lve;

    // ------------------------------------------------------------
    // Mode capture on the first cycle after reset release
    // ------------------------------------------------------------
    if (state_reg.mode_pending) begin
      state_next.mode_pending = 1'b0;
      state_next.mode_muxed = mode_in;
      // Strobe idles low; select two idles high (inactive)
      state_next.pins.as_cs2 = ~mode_in;
    end
    state_next.pins.addr_lo_oe = ~state_reg.mode_muxed;
    state_next.pins.cs1_pin_sel = state_reg.param != `SCCE_PARAM_PORT;
    // Drive starts only after capture so the mode level is not fought
    state_next.pins.lir_oe = ~state_reg.mode_pending
      & state_reg.load_visibility & state_reg.internal_read_visibility;

    // ------------------------------------------------------------
    // Expansion bus cycle
    // ------------------------------------------------------------
    in_page0 = state_reg.addr[15:8] == `SCCE_PAGE0_HI & cpu.page0_ext;
    in_gp = state_reg.addr >= `SCCE_GP_LO
      && state_reg.addr <= `SCCE_GP_HI;
    in_stretch = state_reg.addr >= `SCCE_STRETCH_LO
      && state_reg.addr <= `SCCE_STRETCH_HI;
    cs1_en = state_reg.param != `SCCE_PARAM_PORT;
    cs1_page0 = ~state_reg.mode_muxed
      | (state_reg.param != `SCCE_PARAM_GP);
    cs1_hit = cs1_page0 ? in_page0 : in_gp;

    case (state_reg.st)
      SCCE_IDLE: begin
        // Ack cycle ignores a request the master has not yet dropped
        if (cpu.req & ~state_reg.mode_pending & ~state_reg.so.cpu_ack) begin
          state_next.st = SCCE_ADDR;
          state_next.addr = cpu.addr;
          state_next.wdata = cpu.wdata;
          state_next.is_wr = cpu.wr;
          state_next.visible = ~cpu.internal | state_reg.internal_read_visibility;
          if (~cpu.internal | state_reg.internal_read_visibility) begin
            state_next.pins.addr_hi = cpu.addr[15:8];
            state_next.pins.pgm_sel_n = ~cpu.addr[15];
            state_next.pins.lir_n = ~cpu.opfetch;
            if (state_reg.mode_muxed) begin
              state_next.pins.ad_out = cpu.addr[7:0];
              state_next.pins.ad_oe = 1'b1;
              state_next.pins.as_cs2 = 1'b1;
            end else begin
              state_next.pins.addr_lo = cpu.addr[7:0];
            end
          end else begin
            // Quiet cycle: address holds, data pins show last data
            state_next.pins.ad_out = state_reg.last_data;
            state_next.pins.ad_oe = 1'b1;
          end
        end
      end
      SCCE_ADDR: begin
        state_next.st = SCCE_DATA;
        state_next.stretch_cnt = 4'h0;
        if (state_reg.visible) begin
          state_next.pins.rd_n = state_reg.is_wr;
          state_next.pins.wr_n = ~state_reg.is_wr;
          state_next.pins.cs1_n = ~(cs1_en & cs1_hit);
          state_next.pins.ad_out = state_reg.is_wr ? state_reg.wdata
            : state_reg.last_data;
          state_next.pins.ad_oe = state_reg.is_wr;
          if (state_reg.mode_muxed) begin
            state_next.pins.as_cs2 = 1'b0;
          end else begin
            state_next.pins.as_cs2 = ~in_gp;
          end
          if (cs1_en & cs1_page0 & in_stretch
              & state_reg.param == `SCCE_PARAM_P0_STRETCH) begin
            state_next.stretch_cnt = STRETCH;
            state_next.pins.stretch = 1'b1;
          end
        end
      end
      SCCE_DATA: begin
        if (state_reg.stretch_cnt != 4'h0) begin
          state_next.stretch_cnt = state_reg.stretch_cnt - 4'h1;
        end else begin
          state_next.st = SCCE_IDLE;
          state_next.so.cpu_ack = 1'b1;
          state_next.pins.stretch = 1'b0;
          state_next.pins.rd_n = 1'b1;
          state_next.pins.wr_n = 1'b1;
          state_next.pins.cs1_n = 1'b1;
          state_next.pins.lir_n = 1'b1;
          if (!state_reg.mode_muxed) begin
            state_next.pins.as_cs2 = 1'b1;
          end
          if (state_reg.visible) begin
            if (state_reg.is_wr) begin
              state_next.last_data = state_reg.wdata;
            end else begin
              state_next.last_data = ad_in;
              state_next.so.ext_rdata = ad_in;
            end
          end
        end
      end
      default: begin
        state_next.st = SCCE_IDLE;
      end
    endcase

    // ------------------------------------------------------------
    // Internal resets clear options but not once-per-external bits
    // ------------------------------------------------------------
    if (int_reset) begin
      state_next = reset_val;
      state_next.ext_locked = state_reg.ext_locked;
      state_next.k_sens = state_reg.k_sens;
      state_next.i_sens = state_reg.i_sens;
      state_next.mode_muxed = state_reg.mode_muxed;
      state_next.mode_pending = 1'b0;
      state_next.pins.as_cs2 = ~state_reg.mode_muxed;
    end
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg <= reset_val;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_readdata = {24'h000000, state_reg.rdata};
  assign avs_waitrequest = state_reg.waitreq;
  assign ext = state_reg.pins;
  assign sys = state_reg.so;

endmodule

// ### hw/scce_cfg.svh
`ifndef SCCE_CFG_SVH
`define SCCE_CFG_SVH

// ----------------------------------------------------------------
// Register map (printed indexes; byte address is index times four)
// ----------------------------------------------------------------
`define SCCE_CFG_INDEX 8'h19
`define SCCE_EIC_INDEX 8'h1a
`define SCCE_CFG_RESET 8'h63
`define SCCE_EIC_RESET 8'h04

// ----------------------------------------------------------------
// Option register fields
// ----------------------------------------------------------------
`define SCCE_CFG_STOP_ALLOW 7
`define SCCE_CFG_STOP_REC 6
`define SCCE_CFG_WDOG 5
`define SCCE_CFG_IRV 4
`define SCCE_CFG_LOAD_VISIBILITY 3
`define SCCE_CFG_LVE 2
`define SCCE_CFG_PARAM_HI 1
`define SCCE_CFG_PARAM_LO 0

// ----------------------------------------------------------------
// Interrupt control/status fields
// ----------------------------------------------------------------
`define SCCE_EIC_KFLAG 7
`define SCCE_EIC_KEN 6
`define SCCE_EIC_KACK 5
`define SCCE_EIC_KSENS 4
`define SCCE_EIC_IFLAG 3
`define SCCE_EIC_IEN 2
`define SCCE_EIC_IACK 1
`define SCCE_EIC_ISENS 0

// ----------------------------------------------------------------
// Chip select parameter codes and decode windows
// ----------------------------------------------------------------
`define SCCE_PARAM_P0 2'h0
`define SCCE_PARAM_P0_STRETCH 2'h1
`define SCCE_PARAM_GP 2'h2
`define SCCE_PARAM_PORT 2'h3
`define SCCE_PAGE0_HI 8'h00
`define SCCE_STRETCH_LO 16'h0030
`define SCCE_STRETCH_HI 16'h003f
`define SCCE_GP_LO 16'h4000
`define SCCE_GP_HI 16'h7fff

// ----------------------------------------------------------------
// Timing counts, in sys_clk cycles
// ----------------------------------------------------------------
`define SCCE_REC_FAST_CYCLES 12'h400
`define SCCE_REC_NORMAL_CYCLES 12'hfe0
`define SCCE_STRETCH_CYCLES 4'h4

`endif

// ### hw/scce_pkg.sv
package scce_pkg;

  typedef enum logic [1:0] {
    SCCE_IDLE,
    SCCE_ADDR,
    SCCE_DATA
  } scce_bus_state_t;

  typedef struct packed {
    logic req;
    logic rd;
    logic wr;
    logic internal;
    logic page0_ext;
    logic opfetch;
    logic [15:0] addr;
    logic [7:0] wdata;
  } scce_cpu_req_t;

  typedef struct packed {
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic addr_lo_oe;
    logic [7:0] ad_out;
    logic ad_oe;
    logic as_cs2;
    logic rd_n;
    logic wr_n;
    logic cs1_n;
    logic cs1_pin_sel;
    logic pgm_sel_n;
    logic stretch;
    logic lir_n;
    logic lir_oe;
  } scce_ext_bus_t;

  typedef struct packed {
    logic cpu_ack;
    logic [7:0] ext_rdata;
    logic irq_req;
    logic kbd_req;
    logic ill_stop;
    logic rec_busy;
    logic wdog_en;
    logic lve_en;
  } scce_sys_out_t;

endpackage

// ### verif/scce_assertions.sv
`timescale 1ns/100ps
module scce_checker
  import scce_pkg::*;
#(
  parameter logic [11:0] REC_FAST = 12'h400,
  parameter logic [11:0] REC_NORMAL = 12'hfe0,
  parameter logic [3:0] STRETCH = 4'h4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire scce_ext_bus_t ext,
  input wire scce_sys_out_t sys
);
  logic [11:0] busy_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Bus pins and system outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !sys.rec_busy) begin
      busy_cnt <= 12'h000;
    end else begin
      busy_cnt <= busy_cnt + 12'h001;
    end
  end
  AST_PGM_SEL: assert property (
    !ext.rd_n |-> ext.pgm_sel_n == !ext.addr_hi[7])
    else $error("program select differs from inverted bit 15");
  AST_SEL_WITH_STROBE: assert property (
    !ext.cs1_n |-> (!ext.rd_n || !ext.wr_n))
    else $error("select one low outside a strobe");
  AST_SEP_GP_WINDOW: assert property (
    ext.addr_lo_oe && !ext.as_cs2 && !ext.rd_n
      |-> {ext.addr_hi, ext.addr_lo} inside {[16'h4000:16'h7fff]})
    else $error("select two outside its window");
  AST_SEP_SEL1_PAGE0: assert property (
    ext.addr_lo_oe && !ext.cs1_n |-> ext.addr_hi == 8'h00)
    else $error("separate mode select one not page zero");
  AST_STRETCH_PAGE0: assert property (
    ext.stretch |-> ext.addr_hi == 8'h00)
    else $error("stretch outside page zero");
  AST_MUX_STROBE: assert property (
    $rose(ext.as_cs2) && ext.ad_oe && !ext.addr_lo_oe |=> !ext.as_cs2)
    else $error("address strobe longer than one cycle");
  AST_ILL_STOP: assert property (
    sys.ill_stop |-> $past(sys.ill_stop) == 1'b0)
    else $error("illegal stop pulse longer than one cycle");
  AST_REC_COUNT: assert property (
    $fell(sys.rec_busy) |-> busy_cnt == REC_FAST || busy_cnt == REC_NORMAL)
    else $error("stop recovery length wrong");
  AST_RD_WR_EXCL: assert property (
    !ext.rd_n |-> ext.wr_n ##1 ext.wr_n)
    else $error("read and write strobes overlap");
  COV_STRETCH: cover property (ext.stretch);
  COV_ILL: cover property (sys.ill_stop);
  COV_REC: cover property ($fell(sys.rec_busy));
endmodule

// ### verif/scce_ext_model.sv
`timescale 1ns/100ps
module scce_ext_model
  import scce_pkg::*;
(
  input wire logic sys_clk,
  input wire scce_ext_bus_t ext,
  input wire logic mode_level,
  output logic [7:0] ad_in,
  output logic mode_in
);
  logic [7:0] lo_q;
  logic [7:0] last_q = 8'h00;
  logic [15:0] a;
  // ----------------------------------------
  // External memory on the expansion bus
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (ext.as_cs2 && ext.ad_oe && !ext.addr_lo_oe) begin
      lo_q <= ext.ad_out;
    end
    if (!ext.rd_n) begin
      last_q <= ad_in;
    end
  end
  assign a = {ext.addr_hi, ext.addr_lo_oe ? ext.addr_lo : lo_q};
  // Released lines show the inverse, so a stale byte is never taken
  assign ad_in = !ext.rd_n ? (a[7:0] ^ a[15:8] ^ 8'h5a) : ~last_q;
  // Let go of the mode level once the load indicator owns the pin
  assign mode_in = ext.lir_oe ? ext.lir_n : mode_level;
endmodule

// ### verif/tb.sv
`timescale 1ns/100ps
module tb
  import scce_pkg::*;
;
  localparam logic [11:0] REC_F = 12'h008;
  logic sys_clk, rst_b, int_reset, avs_read, avs_write, avs_waitrequest;
  logic mode_in, mode_lvl, irq_n, vector_fetch, wait_exec, stop_exec;
  logic stop_exit, ill_seen;
  logic [7:0] avs_address, kbd_in, kbd_ddr, ad_in, rd_q;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [3:0] avs_byteenable;
  logic [15:0] a;
  scce_cpu_req_t cpu;
  scce_ext_bus_t ext;
  scce_sys_out_t sys;
  int fail_count = 0, check_count = 0, rd_cnt = 0, busy_n = 0, n0;
  scce_top #(.REC_FAST(REC_F), .REC_NORMAL(12'h010), .STRETCH(4'h4)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .int_reset(int_reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu(cpu), .ad_in(ad_in), .mode_in(mode_in), .irq_n(irq_n),
    .kbd_in(kbd_in), .kbd_ddr(kbd_ddr), .vector_fetch(vector_fetch),
    .stop_exec(stop_exec), .wait_exec(wait_exec), .stop_exit(stop_exit),
    .ext(ext), .sys(sys));
  scce_ext_model u_mem (.sys_clk(sys_clk), .ext(ext),
    .mode_level(mode_lvl), .ad_in(ad_in), .mode_in(mode_in));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] mem_val(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic avs(input logic w, input logic [7:0] ad,
                     input logic [7:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= ad;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e,
                        input string nm);
    avs(1'b0, ad, 8'h00, 4'hf);
    chk(nm, e, rd_q);
  endtask
  task automatic cpu_op(input logic [15:0] ad, input logic intl,
                        input logic p0, input logic w);
    @(posedge sys_clk);
    cpu <= {1'b1, !w, w, intl, p0, 1'b0, ad, mem_val(ad)};
    do begin
      @(posedge sys_clk);
    end while (sys.cpu_ack !== 1'b1);
    cpu.req <= 1'b0;
  endtask
  // k: 4 vector fetch, 3 wait, 2 stop, 1 stop exit, 0 internal reset
  task automatic pulse(input int k);
    @(posedge sys_clk);
    {vector_fetch, wait_exec, stop_exec, stop_exit, int_reset} <= 5'h1 << k;
    @(posedge sys_clk);
    {vector_fetch, wait_exec, stop_exec, stop_exit, int_reset} <= 5'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic do_reset(input logic m);
    mode_lvl <= m;
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic irq_fall();
    @(posedge sys_clk);
    irq_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (ext.rd_n === 1'b0) rd_cnt <= rd_cnt + 1;
    if (stop_exit) busy_n <= 0;
    else if (sys.rec_busy === 1'b1) busy_n <= busy_n + 1;
    if (!rst_b) ill_seen <= 1'b0;
    else if (sys.ill_stop === 1'b1) ill_seen <= 1'b1;
  end
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    {int_reset, avs_read, avs_write, vector_fetch, wait_exec} = '0;
    {stop_exec, stop_exit, rst_b} = '0;
    {avs_address, avs_writedata, avs_byteenable, kbd_ddr} = '0;
    cpu = '0;
    irq_n = 1'b1;
    kbd_in = 8'hff;
    mode_lvl = 1'b1;
    r = 32'h14de;
    do_reset(1'b1);
    rd_chk(8'h64, 8'h63, "option reg");
    chk("cs1_pin_sel", 8'h00, {7'h0, ext.cs1_pin_sel});
    rd_chk(8'h68, 8'h04, "int reg");
    rd_chk(8'h7c, 8'h00, "unmapped");
    avs(1'b1, 8'h64, 8'hb5, 4'hf);
    rd_chk(8'h64, 8'hb5, "option reg");
    chk("cs1_pin_sel", 8'h01, {7'h0, ext.cs1_pin_sel});
    chk("wdog_en", 8'h01, {7'h0, sys.wdog_en});
    chk("lve_en", 8'h01, {7'h0, sys.lve_en});
    avs(1'b1, 8'h64, 8'h59, 4'hf);
    avs(1'b1, 8'h64, 8'h00, 4'h0);
    rd_chk(8'h64, 8'hb9, "option reg");
    chk("lir_oe", 8'h01, {7'h0, ext.lir_oe});
    $display("test registers done");
    r = lfsr(r);
    a = {12'h003, r[3:0]};
    cpu_op(a, 1'b0, 1'b1, 1'b0);
    chk("stretched read", mem_val(a), sys.ext_rdata);
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      a = r[15:0];
      cpu_op(a, 1'b0, 1'b0, 1'b0);
      chk("muxed read", mem_val(a), sys.ext_rdata);
    end
    n0 = rd_cnt;
    cpu_op(16'h0080, 1'b1, 1'b0, 1'b0);
    chk("visible strobe", 8'h01, {7'h0, rd_cnt > n0});
    avs(1'b1, 8'h64, 8'h01, 4'hf);
    n0 = rd_cnt;
    cpu_op(16'h0080, 1'b1, 1'b0, 1'b0);
    chk("quiet strobe", 8'h00, {7'h0, rd_cnt != n0});
    $display("test muxed bus done");
    irq_fall();
    rd_chk(8'h68, 8'h0c, "int reg");
    chk("irq_req", 8'h01, {7'h0, sys.irq_req});
    avs(1'b1, 8'h68, 8'h06, 4'hf);
    rd_chk(8'h68, 8'h04, "int reg");
    irq_n <= 1'b1;
    avs(1'b1, 8'h68, 8'h00, 4'hf);
    irq_fall();
    rd_chk(8'h68, 8'h08, "int reg");
    chk("irq_req", 8'h00, {7'h0, sys.irq_req});
    pulse(4);
    rd_chk(8'h68, 8'h00, "int reg");
    pulse(3);
    rd_chk(8'h68, 8'h04, "int reg");
    irq_n <= 1'b1;
    pulse(2);
    pulse(1);
    repeat (REC_F + 4) @(posedge sys_clk);
    chk("recovery", REC_F[7:0], busy_n[7:0]);
    chk("ill_stop", 8'h00, {7'h0, ill_seen});
    kbd_ddr <= 8'h0f;
    kbd_in <= 8'hfd;
    repeat (4) @(posedge sys_clk);
    avs(1'b1, 8'h68, 8'h44, 4'hf);
    rd_chk(8'h68, 8'h44, "int reg");
    kbd_in <= 8'hed;
    repeat (4) @(posedge sys_clk);
    rd_chk(8'h68, 8'hc4, "int reg");
    chk("kbd_req", 8'h01, {7'h0, sys.kbd_req});
    avs(1'b1, 8'h68, 8'h64, 4'hf);
    rd_chk(8'h68, 8'h44, "int reg");
    kbd_in <= 8'hff;
    // Sensitivity bits were locked by the first write after reset
    avs(1'b1, 8'h68, 8'h15, 4'hf);
    rd_chk(8'h68, 8'h04, "int reg");
    avs(1'b1, 8'h68, 8'h11, 4'hf);
    rd_chk(8'h68, 8'h00, "int reg");
    $display("test interrupts done");
    do_reset(1'b0);
    rd_chk(8'h68, 8'h04, "int reg");
    avs(1'b1, 8'h64, 8'h02, 4'hf);
    rd_chk(8'h64, 8'h02, "option reg");
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      a = i[0] ? {2'b01, r[13:0]} : {10'h003, r[5:0]};
      cpu_op(a, 1'b0, !i[0], 1'b0);
      chk("separate read", mem_val(a), sys.ext_rdata);
    end
    cpu_op(16'h4123, 1'b0, 1'b0, 1'b1);
    chk("write data", mem_val(16'h4123), ext.ad_out);
    pulse(2);
    chk("ill_stop", 8'h01, {7'h0, ill_seen});
    avs(1'b1, 8'h68, 8'h01, 4'hf);
    pulse(0);
    rd_chk(8'h68, 8'h05, "int reg");
    rd_chk(8'h64, 8'h63, "option reg");
    irq_fall();
    avs(1'b1, 8'h68, 8'h06, 4'hf);
    rd_chk(8'h68, 8'h0d, "int reg");
    $display("test separate bus done");
    wrap_up();
  end
endmodule
bind scce_top scce_checker #(.REC_FAST(REC_FAST), .REC_NORMAL(REC_NORMAL),
  .STRETCH(STRETCH)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .ext(ext),
  .sys(sys));
